// ---- rtl/pdsc_pkg.sv ----
// package: constants and types for the power-down start control block
package pdsc_pkg;
  // register byte offsets (chosen map)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_RET_A = 8'h10;
  localparam logic [7:0] ADDR_RET_B = 8'h14;
  localparam logic [7:0] ADDR_INIT_A = 8'h18;
  localparam logic [7:0] ADDR_INIT_B = 8'h1C;
  // control register command bits (write one to issue)
  localparam int CMD_ARM = 0;
  localparam int CMD_CLK_SLEEP = 1;
  localparam int CMD_RAM_SLEEP = 2;
  localparam int CMD_OTHER = 3;
  localparam int CMD_SKIP = 4;
  // status bit whose write-one clears the timer5 request flag
  localparam int STAT_T5_CLR = 2;
  // irq status bits
  localparam int IRQ_WARM = 0;
  localparam int IRQ_COLD = 1;
  localparam int IRQ_SLEEP = 2;
  localparam int IRQ_NOP = 3;
  localparam int IRQ_W = 4;
  // reset / init values
  localparam logic [13:0] PC_START = 14'h0000;
  localparam logic [2:0] SP_INIT = 3'h7;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PDSC_RUN,
    PDSC_CLK_SLEEP,
    PDSC_RAM_SLEEP
  } pdsc_state_e;

  // state initialized on every return from sleep
  typedef struct packed {
    logic [13:0] pc;
    logic [3:0] acc;
    logic [3:0] reg_b;
    logic carry;
    logic [2:0] sp;
    logic [3:0] int_en_a;
    logic [3:0] int_en_b;
    logic [3:0] prescaler;
    logic [3:0] timer4_ctl;
    logic conv_done;
    logic serial_done;
    logic wdog_one;
    logic wdog_two;
  } pdsc_init_s;

  // retained control group, 8 nibbles in word a, 6 nibbles and a spare byte in word b
  typedef struct packed {
    logic [3:0] timer1_ctl;
    logic [3:0] timer3_ctl;
    logic [3:0] timer5_ctl;
    logic [3:0] lcd_timer_ctl;
    logic [3:0] serial_mode;
    logic [3:0] conv_ctl_a;
    logic [3:0] conv_ctl_c;
    logic [3:0] lcd_ctl_a;
  } pdsc_ret_a_s;

  typedef struct packed {
    logic [3:0] lcd_ctl_b;
    logic [3:0] pullup_p0;
    logic [3:0] pullup_p1;
    logic [3:0] key_wake_p0;
    logic [3:0] key_wake_p1;
    logic [3:0] key_wake_ext;
    logic [7:0] spare;
  } pdsc_ret_b_s;
endpackage

// ---- rtl/pdsc_ctrl.sv ----
// power-down start control: warm/cold start, sleep entry, retention, axi4-lite regs
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - wake on external input or timer5 underflow
// RULE_02 - warm start: pc zero, power-down flag set
// RULE_03 - pin, watchdog, voltage reset: cold start, flag clear
// RULE_04 - skip instruction tests power-down flag
// RULE_05 - timer5 request flag readable after wakeup
// RULE_06 - pc, acc, b, carry, sp initialized
// RULE_07 - both interrupt enable registers initialized
// RULE_08 - prescaler and timer4 control initialized
// RULE_09 - timer 1-3, 5, lcd timer controls retained (only timer1, timer3, timer5 and lcd timer fields are kept here)
// RULE_10 - serial, converter, lcd controls retained
// RULE_11 - pull-up and key-wake controls retained
// RULE_12 - timer1-4 request flags undefined after return
// RULE_13 - converter done flag initialized on return
// RULE_14 - serial done flag initialized on return
// RULE_15 - both watchdog flags initialized on return
// RULE_16 - sleep only if arm immediately precedes
// RULE_17 - ram backup return sets sp to 7
// RULE_18 - ram backup wakes only on external input
module pdsc_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic wdog_reset,
  input wire logic vdrop_reset,
  input wire logic ext_wake,
  input wire logic timer5_underflow,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sleeping,
  output logic osc_stopped,
  output logic core_restart,
  output logic skip_next,
  output logic irq
);
  // external inputs: two-flop synchronisers
  logic [4:0] meta_ff;
  logic [4:0] sync_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 5'h00;
      sync_ff <= 5'h00;
    end else begin
      meta_ff <= {~reset_pin_n, wdog_reset, vdrop_reset, ext_wake, timer5_underflow};
      sync_ff <= meta_ff;
    end
  end
  wire pin_rst = sync_ff[4];
  wire wd_rst = sync_ff[3];
  wire vd_rst = sync_ff[2];
  wire wake_ext = sync_ff[1];
  wire t5_uf = sync_ff[0];
  wire cold = pin_rst | wd_rst | vd_rst; // RULE_03
  logic cold_q_ff;
  // restart pulses once per cold event, not for as long as the source holds
  wire cold_start = cold & ~cold_q_ff;

  // axi4-lite write channel
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  wire aw_take = s_axi_awvalid & ~aw_hold_ff & ~bvalid_ff;
  wire w_take = s_axi_wvalid & ~w_hold_ff & ~bvalid_ff;
  wire wr_fire = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  wire [7:0] wr_addr = awaddr_ff;
  wire wr_ctrl = wr_fire & (wr_addr == pdsc_pkg::ADDR_CTRL) & wstrb_ff[0];
  wire wr_istat = wr_fire & (wr_addr == pdsc_pkg::ADDR_IRQ_STAT) & wstrb_ff[0];
  wire wr_imask = wr_fire & (wr_addr == pdsc_pkg::ADDR_IRQ_MASK) & wstrb_ff[0];
  wire wr_reta = wr_fire & (wr_addr == pdsc_pkg::ADDR_RET_A);
  wire wr_retb = wr_fire & (wr_addr == pdsc_pkg::ADDR_RET_B);
  wire wr_inita = wr_fire & (wr_addr == pdsc_pkg::ADDR_INIT_A);
  wire wr_initb = wr_fire & (wr_addr == pdsc_pkg::ADDR_INIT_B);
  wire wr_mapped = wr_addr == pdsc_pkg::ADDR_CTRL || wr_addr == pdsc_pkg::ADDR_STATUS ||
    wr_addr == pdsc_pkg::ADDR_IRQ_STAT || wr_addr == pdsc_pkg::ADDR_IRQ_MASK ||
    wr_addr == pdsc_pkg::ADDR_RET_A || wr_addr == pdsc_pkg::ADDR_RET_B ||
    wr_addr == pdsc_pkg::ADDR_INIT_A || wr_addr == pdsc_pkg::ADDR_INIT_B;
  wire [1:0] nxt_bresp = wr_mapped ? pdsc_pkg::RESP_OKAY : pdsc_pkg::RESP_SLVERR;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= nxt_bresp;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  // readies registered so every port leaves a flop
  logic awready_ff;
  logic wready_ff;
  wire nxt_bvalid = wr_fire | (bvalid_ff & ~s_axi_bready);
  wire nxt_aw_hold = ~wr_fire & (aw_hold_ff | aw_take);
  wire nxt_w_hold = ~wr_fire & (w_hold_ff | w_take);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
    end else begin
      awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
      wready_ff <= ~nxt_w_hold & ~nxt_bvalid;
    end
  end
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // instruction strobes from the core, modelled as control writes
  wire cmd_arm = wr_ctrl & wdata_ff[pdsc_pkg::CMD_ARM];
  wire cmd_clk = wr_ctrl & wdata_ff[pdsc_pkg::CMD_CLK_SLEEP];
  wire cmd_ram = wr_ctrl & wdata_ff[pdsc_pkg::CMD_RAM_SLEEP];
  wire cmd_other = wr_ctrl & wdata_ff[pdsc_pkg::CMD_OTHER];
  wire cmd_skip = wr_ctrl & wdata_ff[pdsc_pkg::CMD_SKIP];

  // sleep state machine
  pdsc_pkg::pdsc_state_e state_ff;
  pdsc_pkg::pdsc_state_e nxt_state;
  logic armed_ff;
  logic pd_flag_ff;
  logic t5_flag_ff;
  logic restart_ff;
  logic skip_ff;
  wire running = state_ff == pdsc_pkg::PDSC_RUN;
  // arm must be the instruction directly before; any other one disarms
  wire sleep_ok = armed_ff & ~cmd_arm & ~cmd_other; // RULE_16
  wire go_clk = running & cmd_clk & sleep_ok & ~cmd_ram; // RULE_16
  wire go_ram = running & cmd_ram & sleep_ok; // RULE_16
  wire sleep_nop = running & (cmd_clk | cmd_ram) & ~sleep_ok;
  // oscillator stopped: timer5 cannot wake ram backup
  wire wake_clk = (state_ff == pdsc_pkg::PDSC_CLK_SLEEP) & (wake_ext | t5_uf); // RULE_01
  wire wake_ram = (state_ff == pdsc_pkg::PDSC_RAM_SLEEP) & wake_ext; // RULE_18
  wire warm = (wake_clk | wake_ram) & ~cold;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pdsc_pkg::PDSC_RUN: begin
        if (go_ram) nxt_state = pdsc_pkg::PDSC_RAM_SLEEP;
        else if (go_clk) nxt_state = pdsc_pkg::PDSC_CLK_SLEEP;
      end
      pdsc_pkg::PDSC_CLK_SLEEP,
      pdsc_pkg::PDSC_RAM_SLEEP: begin
        if (warm) nxt_state = pdsc_pkg::PDSC_RUN;
      end
    endcase
    if (cold) nxt_state = pdsc_pkg::PDSC_RUN;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= pdsc_pkg::PDSC_RUN;
      armed_ff <= 1'b0;
      pd_flag_ff <= 1'b0;
      restart_ff <= 1'b0;
      skip_ff <= 1'b0;
      cold_q_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (wr_ctrl) armed_ff <= cmd_arm & running; // RULE_16
      if (cold) pd_flag_ff <= 1'b0; // RULE_03
      else if (warm) pd_flag_ff <= 1'b1; // RULE_02
      cold_q_ff <= cold;
      restart_ff <= cold_start | warm; // RULE_02 RULE_03
      skip_ff <= cmd_skip & pd_flag_ff; // RULE_04
    end
  end

  // timer5 request flag: survives wake, cleared by writing one to status bit 2; it reads back at status bit 3
  wire t5_clr = wr_fire & (wr_addr == pdsc_pkg::ADDR_STATUS) &
    wdata_ff[pdsc_pkg::STAT_T5_CLR];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) t5_flag_ff <= 1'b0;
    else if (t5_uf) t5_flag_ff <= 1'b1; // RULE_05
    else if (t5_clr) t5_flag_ff <= 1'b0;
  end

  // initialized state: cleared on every start, warm or cold, except sp which loads 7
  pdsc_pkg::pdsc_init_s init_ff;
  wire restart_now = cold | warm;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_ff <= '0;
      init_ff.sp <= pdsc_pkg::SP_INIT;
    end else if (restart_now) begin
      init_ff <= '0; // RULE_06 RULE_07 RULE_08 RULE_13 RULE_14 RULE_15
      init_ff.pc <= pdsc_pkg::PC_START; // RULE_02
      init_ff.sp <= pdsc_pkg::SP_INIT; // RULE_17
    end else if (wr_inita) begin
      init_ff[35:4] <= wdata_ff;
    end else if (wr_initb) begin
      init_ff[3:0] <= wdata_ff[3:0];
    end
  end

  // retained controls: only cold reset clears them, sleep never touches them
  pdsc_pkg::pdsc_ret_a_s ret_a_ff;
  pdsc_pkg::pdsc_ret_b_s ret_b_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ret_a_ff <= '0;
      ret_b_ff <= '0;
    end else if (cold) begin
      ret_a_ff <= '0;
      ret_b_ff <= '0;
    end else begin
      if (wr_reta) ret_a_ff <= wdata_ff; // RULE_09 RULE_10
      if (wr_retb) ret_b_ff <= {wdata_ff[31:8], 8'h00}; // RULE_10 RULE_11
    end
  end
  // timer1-4 request flags live in the timers; their state after return is undefined,
  // so this block keeps no copy and reports none (RULE_12)

  // interrupts: sticky, write one to clear, set wins
  logic [pdsc_pkg::IRQ_W-1:0] istat_ff;
  logic [pdsc_pkg::IRQ_W-1:0] imask_ff;
  logic irq_ff;
  wire [pdsc_pkg::IRQ_W-1:0] ev = {sleep_nop, go_clk | go_ram, cold, warm};
  wire [pdsc_pkg::IRQ_W-1:0] iclr = wr_istat ? wdata_ff[pdsc_pkg::IRQ_W-1:0] : '0;
  wire [pdsc_pkg::IRQ_W-1:0] nxt_istat = (istat_ff & ~iclr) | ev;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_ff <= '0;
      imask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      istat_ff <= nxt_istat;
      if (wr_imask) imask_ff <= wdata_ff[pdsc_pkg::IRQ_W-1:0];
      irq_ff <= |(nxt_istat & imask_ff);
    end
  end

  // axi4-lite read channel
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  wire rd_take = s_axi_arvalid & ~rvalid_ff;
  wire [31:0] status_word = {27'h0, armed_ff, t5_flag_ff, pd_flag_ff, // RULE_04 RULE_05
    state_ff == pdsc_pkg::PDSC_RAM_SLEEP, ~running};
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (rd_addr)
      pdsc_pkg::ADDR_CTRL: rd_mux = 32'h0000_0000;
      pdsc_pkg::ADDR_STATUS: rd_mux = status_word;
      pdsc_pkg::ADDR_IRQ_STAT: rd_mux = {28'h0, istat_ff};
      pdsc_pkg::ADDR_IRQ_MASK: rd_mux = {28'h0, imask_ff};
      pdsc_pkg::ADDR_RET_A: rd_mux = ret_a_ff;
      pdsc_pkg::ADDR_RET_B: rd_mux = ret_b_ff;
      pdsc_pkg::ADDR_INIT_A: rd_mux = init_ff[35:4];
      pdsc_pkg::ADDR_INIT_B: rd_mux = {28'h0, init_ff[3:0]};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_hit ? pdsc_pkg::RESP_OKAY : pdsc_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  logic arready_ff;
  wire nxt_rvalid = rd_take | (rvalid_ff & ~s_axi_rready);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) arready_ff <= 1'b1;
    else arready_ff <= ~nxt_rvalid;
  end
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // core-facing outputs
  logic sleeping_ff;
  logic osc_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleeping_ff <= 1'b0;
      osc_ff <= 1'b0;
    end else begin
      sleeping_ff <= nxt_state != pdsc_pkg::PDSC_RUN;
      osc_ff <= nxt_state == pdsc_pkg::PDSC_RAM_SLEEP;
    end
  end
  assign sleeping = sleeping_ff;
  assign osc_stopped = osc_ff;
  assign core_restart = restart_ff;
  assign skip_next = skip_ff;
  assign irq = irq_ff;

  // checks
  // commands arrive many cycles apart, so arming is judged by armed_ff
  sequence armed_sleep_s;
    running && armed_ff && (cmd_clk || cmd_ram) && !cmd_arm && !cmd_other && !cold;
  endsequence
  sequence asleep_s;
    !running && sleeping;
  endsequence
  warm_sets_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_02
    warm |=> pd_flag_ff && restart_ff) else $error("warm start did not set flag");
  cold_clears_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_03
    cold |=> !pd_flag_ff && restart_ff == $past(cold_start))
    else $error("cold start left flag set");
  ram_no_timer_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_18
    (state_ff == pdsc_pkg::PDSC_RAM_SLEEP && !wake_ext && !cold) |=> !running)
    else $error("ram backup left without external wake");
  clk_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_01
    (state_ff == pdsc_pkg::PDSC_CLK_SLEEP && t5_uf) |=> running)
    else $error("timer5 underflow did not wake");
  nop_without_arm_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_16
    (running && cmd_clk && !armed_ff) |=> running) else $error("sleep without arm");
  sp_init_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_17
    restart_now |=> init_ff.sp == pdsc_pkg::SP_INIT) else $error("stack pointer not 7");
  init_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_15
    restart_now |=> !init_ff.wdog_one && !init_ff.wdog_two && !init_ff.conv_done)
    else $error("flags not initialized");
  retain_ctl_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_09
    (warm && !wr_reta) |=> $stable(ret_a_ff)) else $error("retained controls changed");
  t5_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_05
    t5_uf |=> t5_flag_ff [*2] or (t5_flag_ff ##1 1'b1)) else $error("timer5 flag lost");
  skip_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_04
    cmd_skip |=> skip_next == $past(pd_flag_ff)) else $error("skip wrong");
  arm_sleep_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_16
    armed_sleep_s |=> asleep_s) else $error("armed sleep not entered");
  restart_once_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_03
    core_restart |=> !core_restart) else $error("restart pulse too long");
  t5_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_05
    (t5_clr && !t5_uf) |=> !t5_flag_ff) else $error("timer5 flag not cleared");
endmodule // pdsc_ctrl

// ---- verif/pdsc_ctrl_tb_top.sv ----
// self-checking testbench for the power-down start control block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pdsc_ctrl_tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_n = 1'b1;
  logic wdog_reset = 1'b0, vdrop_reset = 1'b0, ext_wake = 1'b0, timer5_underflow = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd_data;
  logic sleeping, osc_stopped, core_restart, skip_next, irq;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int n_rst = 0;
  int n_skip = 0;
  int nr, ns;
  // init word: pc low, acc, b, carry zero, sp 7, then zeroed enables and controls
  localparam logic [31:0] INIT_A_EXP = {13'h0, pdsc_pkg::SP_INIT, 16'h0000};
  localparam logic [31:0] ALL = 32'hFFFFFFFF;

  always #50 ref_clk = ~ref_clk;

  pdsc_ctrl u_pdsc_ctrl (
    .ref_clk(ref_clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .wdog_reset(wdog_reset),
    .vdrop_reset(vdrop_reset), .ext_wake(ext_wake), .timer5_underflow(timer5_underflow),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sleeping(sleeping),
    .osc_stopped(osc_stopped), .core_restart(core_restart), .skip_next(skip_next), .irq(irq)
  );

  // pulse outputs stand one cycle; count them mid-cycle where they are settled
  always @(negedge ref_clk) begin
    cyc++;
    if (core_restart === 1'b1) n_rst++;
    if (skip_next === 1'b1) n_skip++;
    if (cyc == 30000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_ok;
    bit w_ok;
    bit aw_hit;
    bit w_hit;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= {24'h000000, a};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // readies sampled mid-cycle: the value the next rising edge will see
    while (!(aw_ok && w_ok)) begin
      @(negedge ref_clk);
      aw_hit = !aw_ok && s_axi_awready === 1'b1;
      w_hit = !w_ok && s_axi_wready === 1'b1;
      @(posedge ref_clk);
      if (aw_hit) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (w_hit) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(negedge ref_clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge ref_clk); while (s_axi_arready !== 1'b1);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge ref_clk); while (s_axi_rvalid !== 1'b1);
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    `CHK(rd_data & m, e)
  endtask

  // sync flops add latency, so each source is held well past it
  task automatic pulse(input int k);
    @(posedge ref_clk);
    drv(k, 1'b1);
    repeat (6) @(posedge ref_clk);
    drv(k, 1'b0);
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic drv(input int k, input logic on);
    case (k)
      0: timer5_underflow <= on;
      1: ext_wake <= on;
      2: reset_pin_n <= !on;
      3: wdog_reset <= on;
      default: vdrop_reset <= on;
    endcase
  endtask

  task automatic go_sleep(input int c);
    wr(pdsc_pkg::ADDR_CTRL, 32'h1 << pdsc_pkg::CMD_ARM);
    wr(pdsc_pkg::ADDR_CTRL, 32'h1 << c);
    @(posedge ref_clk);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_rd(pdsc_pkg::ADDR_STATUS, ALL, 32'h0);
    chk_rd(pdsc_pkg::ADDR_CTRL, ALL, 32'h0);
    chk_rd(pdsc_pkg::ADDR_INIT_A, ALL, INIT_A_EXP);
    rd(8'h40);
    `CHK(resp, pdsc_pkg::RESP_SLVERR)
    `CHK(rd_data, 32'h0)
    wr(8'h40, 32'h0);
    `CHK(resp, pdsc_pkg::RESP_SLVERR)
    wr(pdsc_pkg::ADDR_IRQ_STAT, 32'h1F);
    `CHK(resp, pdsc_pkg::RESP_OKAY)
    wr(pdsc_pkg::ADDR_IRQ_MASK, 32'h1F);
    chk_rd(pdsc_pkg::ADDR_IRQ_MASK, ALL, 32'hF);
    $display("test reset_map done");
    wr(pdsc_pkg::ADDR_CTRL, 32'h1 << pdsc_pkg::CMD_ARM);
    wr(pdsc_pkg::ADDR_CTRL, 32'h1 << pdsc_pkg::CMD_OTHER);
    wr(pdsc_pkg::ADDR_CTRL, 32'h1 << pdsc_pkg::CMD_CLK_SLEEP);
    `CHK(sleeping, 1'b0)
    wr(pdsc_pkg::ADDR_CTRL, 32'h3);
    `CHK(sleeping, 1'b0)
    chk_rd(pdsc_pkg::ADDR_IRQ_STAT, 32'h8, 32'h8);
    $display("test unarmed done");
    wr(pdsc_pkg::ADDR_RET_A, 32'h12345678);
    wr(pdsc_pkg::ADDR_RET_B, 32'hABCDEF00);
    wr(pdsc_pkg::ADDR_INIT_A, ALL);
    wr(pdsc_pkg::ADDR_INIT_B, 32'hF);
    chk_rd(pdsc_pkg::ADDR_INIT_A, ALL, ALL);
    chk_rd(pdsc_pkg::ADDR_INIT_B, ALL, 32'hF);
    wr(pdsc_pkg::ADDR_IRQ_STAT, 32'h1F);
    nr = n_rst;
    go_sleep(pdsc_pkg::CMD_CLK_SLEEP);
    `CHK(sleeping, 1'b1)
    `CHK(osc_stopped, 1'b0)
    pulse(0);
    `CHK(sleeping, 1'b0)
    `CHK(n_rst, nr + 1)
    chk_rd(pdsc_pkg::ADDR_STATUS, ALL, 32'hC);
    chk_rd(pdsc_pkg::ADDR_RET_A, ALL, 32'h12345678);
    chk_rd(pdsc_pkg::ADDR_RET_B, 32'hFFFFFF00, 32'hABCDEF00);
    chk_rd(pdsc_pkg::ADDR_INIT_A, ALL, INIT_A_EXP);
    chk_rd(pdsc_pkg::ADDR_INIT_B, ALL, 32'h0);
    ns = n_skip;
    wr(pdsc_pkg::ADDR_CTRL, 32'h1 << pdsc_pkg::CMD_SKIP);
    repeat (2) @(posedge ref_clk);
    `CHK(n_skip, ns + 1)
    chk_rd(pdsc_pkg::ADDR_IRQ_STAT, 32'h5, 32'h5);
    `CHK(irq, 1'b1)
    wr(pdsc_pkg::ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    wr(pdsc_pkg::ADDR_IRQ_MASK, 32'hF);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    wr(pdsc_pkg::ADDR_IRQ_STAT, 32'h1F);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    wr(pdsc_pkg::ADDR_STATUS, 32'h1 << pdsc_pkg::STAT_T5_CLR);
    chk_rd(pdsc_pkg::ADDR_STATUS, 32'h8, 32'h0);
    $display("test warm_clock done");
    go_sleep(pdsc_pkg::CMD_RAM_SLEEP);
    `CHK(osc_stopped, 1'b1)
    pulse(0);
    `CHK(sleeping, 1'b1)
    pulse(1);
    `CHK(sleeping, 1'b0)
    chk_rd(pdsc_pkg::ADDR_INIT_A, ALL, INIT_A_EXP);
    chk_rd(pdsc_pkg::ADDR_RET_A, ALL, 32'h12345678);
    $display("test warm_ram done");
    // pin, watchdog and voltage-drop sources in turn
    for (int k = 2; k < 5; k++) begin
      go_sleep(pdsc_pkg::CMD_CLK_SLEEP);
      nr = n_rst;
      pulse(k);
      `CHK(sleeping, 1'b0)
      `CHK(n_rst, nr + 1)
      chk_rd(pdsc_pkg::ADDR_STATUS, 32'h4, 32'h0);
      ns = n_skip;
      wr(pdsc_pkg::ADDR_CTRL, 32'h1 << pdsc_pkg::CMD_SKIP);
      repeat (2) @(posedge ref_clk);
      `CHK(n_skip, ns)
    end
    chk_rd(pdsc_pkg::ADDR_RET_A, ALL, 32'h0);
    $display("test cold done");
    wrap_up();
  end
endmodule // pdsc_ctrl_tb_top
